// File: design/sco_pkg.sv
package sco_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned COORD_W = 12;
	localparam int unsigned RGB_W = 24;
	localparam int unsigned PAT_AW = 10;
	localparam int unsigned PAT_DEPTH = 1024;
	localparam int unsigned SPR_AW = 6;

	// Register indices
	localparam logic [7:0] REG_CURSOR_CONTROL = 8'h06;
	localparam logic [7:0] REG_PAT_ADDR_LO = 8'h08;
	localparam logic [7:0] REG_PAT_ADDR_HI = 8'h09;
	localparam logic [7:0] REG_PAT_DATA = 8'h0A;
	localparam logic [7:0] REG_POS_X_LO = 8'h0C;
	localparam logic [7:0] REG_POS_X_HI = 8'h0D;
	localparam logic [7:0] REG_POS_Y_LO = 8'h0E;
	localparam logic [7:0] REG_POS_Y_HI = 8'h0F;
	localparam logic [7:0] REG_ORIGIN_X = 8'h10;
	localparam logic [7:0] REG_ORIGIN_Y = 8'h11;
	localparam logic [7:0] REG_COLOR0_BASE = 8'h12;
	localparam logic [7:0] REG_COLOR1_BASE = 8'h15;
	localparam logic [7:0] REG_STATUS = 8'h18;
	localparam logic [7:0] REG_COLOR_LAST = 8'h17;

	// Cursor control fields
	localparam int unsigned CC_WIDTH_LSB = 0;
	localparam int unsigned CC_XHAIR_EN = 2;
	localparam int unsigned CC_XHAIR_COLOR = 3;
	localparam int unsigned CC_ALT_ENC = 4;
	localparam int unsigned CC_ISECT = 5;
	localparam int unsigned CC_SPRITE_EN = 6;

	localparam logic [7:0] CURSOR_CONTROL_RST = 8'h00;
	localparam logic [5:0] ORIGIN_RST = 6'h1F;
	localparam logic [11:0] LINE_Y_RST = 12'hFFF;
	localparam logic [1:0] SYNC_CNT_MAX = 2'h2;
	localparam logic [1:0] SYNC_CNT_RETRACE = 2'h1;
	localparam logic [7:0] STAT_MASK = 8'h00;

	typedef enum logic [1:0] {
		SCO_CUR_C0 = 2'h0,
		SCO_CUR_C1 = 2'h1,
		SCO_CUR_CLEAR = 2'h3,
		SCO_CUR_INVERT = 2'h2
	} sco_cur_type;

	typedef struct packed {
		logic blank;
		logic sync_n;
		logic [RGB_W-1:0] rgb;
	} sco_video_type;

endpackage

// File: design/sco_overlay.sv
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
// Contract
// - X rightward, Y downward, first pixel (0,0)
// - Control at index 06, bits1:0 crosshair thickness
// - Bit2 crosshair enable, bit3 crosshair color
// - Bit4 selects primary or alternate encoding
// - Bit5 intersection color, bit6 sprite enable
// - Non-interlaced timing only
// - Pattern RAM not reset, top-left is zero
// - Address at 08/09, data writes auto-increment
// - Data reads return byte then increment
// - Reads and writes share one address
// - Sync inputs are active low
// - Multiple syncs in blank mean retrace
// - Pattern gives two bits each pixel
// - Plane bits decode per selected encoding
// - Transparent passes, complement inverts pixel
// - Sprite origin resets to (31,31)
module sco_overlay
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input sco_pkg::sco_video_type video_in,
	output sco_pkg::sco_video_type video_out
);

	logic [7:0] cursor_control_q;
	logic [sco_pkg::PAT_AW-1:0] pat_addr_q;
	logic [sco_pkg::COORD_W-1:0] pos_x_q;
	logic [sco_pkg::COORD_W-1:0] pos_y_q;
	logic [5:0] origin_x_q;
	logic [5:0] origin_y_q;
	logic [7:0] color_q [0:5];
	logic [7:0] pat_ram [0:sco_pkg::PAT_DEPTH-1];
	logic [7:0] rdata_q;
	logic [sco_pkg::COORD_W-1:0] pix_x_q;
	logic [sco_pkg::COORD_W-1:0] line_y_q;
	logic [sco_pkg::COORD_W-1:0] line_y_d;
	logic blank_prev_q;
	logic sync_prev_q;
	logic [1:0] sync_cnt_q;
	logic line_start;
	logic retrace_seen_q;
	sco_pkg::sco_video_type video_q;
	logic [sco_pkg::COORD_W-1:0] rel_x;
	logic [sco_pkg::COORD_W-1:0] rel_y;
	logic in_sprite;
	logic [7:0] spr_byte;
	logic [1:0] spr_bits;
	sco_pkg::sco_cur_type spr_kind;
	logic sprite_vis;
	logic xhair_on;
	logic [sco_pkg::COORD_W-1:0] dx;
	logic [sco_pkg::COORD_W-1:0] dy;
	logic [sco_pkg::COORD_W-1:0] half_w;
	logic [sco_pkg::RGB_W-1:0] color0;
	logic [sco_pkg::RGB_W-1:0] color1;
	logic [sco_pkg::RGB_W-1:0] rgb_d;
	logic [sco_pkg::RGB_W-1:0] xhair_rgb;
	logic [sco_pkg::RGB_W-1:0] spr_rgb;

	function automatic logic is_pat_data(input logic [7:0] addr);
		is_pat_data = (addr == sco_pkg::REG_PAT_DATA);
	endfunction

	function automatic sco_pkg::sco_cur_type decode_bits(input logic [1:0] bits, input logic alt);
		if (!alt)
		begin
			case (bits)
				2'h0: decode_bits = sco_pkg::SCO_CUR_C0;
				2'h1: decode_bits = sco_pkg::SCO_CUR_C1;
				2'h2: decode_bits = sco_pkg::SCO_CUR_CLEAR;
				default: decode_bits = sco_pkg::SCO_CUR_INVERT;
			endcase
		end
		else
		begin
			case (bits)
				2'h2: decode_bits = sco_pkg::SCO_CUR_C0;
				2'h3: decode_bits = sco_pkg::SCO_CUR_C1;
				default: decode_bits = sco_pkg::SCO_CUR_CLEAR;
			endcase
		end
	endfunction

	function automatic logic [sco_pkg::COORD_W-1:0] abs_diff(
		input logic [sco_pkg::COORD_W-1:0] a,
		input logic [sco_pkg::COORD_W-1:0] b);
		abs_diff = (a >= b) ? a - b : b - a;
	endfunction

	// Host register writes
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			cursor_control_q <= sco_pkg::CURSOR_CONTROL_RST;
			pos_x_q <= '0;
			pos_y_q <= '0;
			origin_x_q <= sco_pkg::ORIGIN_RST;
			origin_y_q <= sco_pkg::ORIGIN_RST;
		end
		else if (reg_wr_in)
		begin
			if (reg_addr_in == sco_pkg::REG_CURSOR_CONTROL)
				cursor_control_q <= reg_wdata_in;
			else if (reg_addr_in == sco_pkg::REG_POS_X_LO)
				pos_x_q[7:0] <= reg_wdata_in;
			else if (reg_addr_in == sco_pkg::REG_POS_X_HI)
				pos_x_q[sco_pkg::COORD_W-1:8] <= reg_wdata_in[sco_pkg::COORD_W-9:0];
			else if (reg_addr_in == sco_pkg::REG_POS_Y_LO)
				pos_y_q[7:0] <= reg_wdata_in;
			else if (reg_addr_in == sco_pkg::REG_POS_Y_HI)
				pos_y_q[sco_pkg::COORD_W-1:8] <= reg_wdata_in[sco_pkg::COORD_W-9:0];
			else if (reg_addr_in == sco_pkg::REG_ORIGIN_X)
				origin_x_q <= reg_wdata_in[5:0];
			else if (reg_addr_in == sco_pkg::REG_ORIGIN_Y)
				origin_y_q <= reg_wdata_in[5:0];
		end
	end

	// Cursor colors, three bytes each, red first
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_color
			always_ff @(posedge ref_clk_in)
			begin
				if (srst_in)
					color_q[gi] <= '0;
				else if (reg_wr_in && reg_addr_in == sco_pkg::REG_COLOR0_BASE + 8'(gi))
					color_q[gi] <= reg_wdata_in;
			end
		end
	endgenerate

	assign color0 = {color_q[0], color_q[1], color_q[2]};
	assign color1 = {color_q[3], color_q[4], color_q[5]};

	// One address serves both directions, so an interrupted access must save both bytes
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			pat_addr_q <= '0;
		else if (reg_wr_in && reg_addr_in == sco_pkg::REG_PAT_ADDR_LO)
			pat_addr_q[7:0] <= reg_wdata_in;
		else if (reg_wr_in && reg_addr_in == sco_pkg::REG_PAT_ADDR_HI)
			pat_addr_q[sco_pkg::PAT_AW-1:8] <= reg_wdata_in[sco_pkg::PAT_AW-9:0];
		else if ((reg_wr_in || reg_rd_in) && is_pat_data(reg_addr_in))
			pat_addr_q <= pat_addr_q + 1'b1;
	end

	// Pattern storage has no reset; contents are undefined until loaded
	always_ff @(posedge ref_clk_in)
	begin
		if (reg_wr_in && is_pat_data(reg_addr_in))
			pat_ram[pat_addr_q] <= reg_wdata_in;
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in || !reg_rd_in)
			rdata_q <= '0;
		else if (reg_addr_in == sco_pkg::REG_CURSOR_CONTROL)
			rdata_q <= cursor_control_q;
		else if (reg_addr_in == sco_pkg::REG_PAT_ADDR_LO)
			rdata_q <= pat_addr_q[7:0];
		else if (reg_addr_in == sco_pkg::REG_PAT_ADDR_HI)
			rdata_q <= 8'(pat_addr_q[sco_pkg::PAT_AW-1:8]);
		else if (is_pat_data(reg_addr_in))
			rdata_q <= pat_ram[pat_addr_q];
		else if (reg_addr_in == sco_pkg::REG_POS_X_LO)
			rdata_q <= pos_x_q[7:0];
		else if (reg_addr_in == sco_pkg::REG_POS_X_HI)
			rdata_q <= 8'(pos_x_q[sco_pkg::COORD_W-1:8]);
		else if (reg_addr_in == sco_pkg::REG_POS_Y_LO)
			rdata_q <= pos_y_q[7:0];
		else if (reg_addr_in == sco_pkg::REG_POS_Y_HI)
			rdata_q <= 8'(pos_y_q[sco_pkg::COORD_W-1:8]);
		else if (reg_addr_in == sco_pkg::REG_ORIGIN_X)
			rdata_q <= 8'(origin_x_q);
		else if (reg_addr_in == sco_pkg::REG_ORIGIN_Y)
			rdata_q <= 8'(origin_y_q);
		else if (reg_addr_in >= sco_pkg::REG_COLOR0_BASE && reg_addr_in <= sco_pkg::REG_COLOR_LAST)
			rdata_q <= color_q[3'(reg_addr_in - sco_pkg::REG_COLOR0_BASE)];
		else if (reg_addr_in == sco_pkg::REG_STATUS)
			rdata_q <= {5'h00, retrace_seen_q, sprite_vis, video_in.blank};
		else
			rdata_q <= sco_pkg::STAT_MASK;
	end

	assign reg_rdata_out = rdata_q;

	// Screen tracking. Interlaced frames would repeat line numbers; only progressive scan works.
	assign line_start = blank_prev_q && !video_in.blank;

	always_comb
	begin
		line_y_d = line_y_q;
		if (line_start)
		begin
			if (sync_cnt_q > sco_pkg::SYNC_CNT_RETRACE)
				line_y_d = '0;
			else
				line_y_d = line_y_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			blank_prev_q <= 1'b1;
			sync_prev_q <= 1'b1;
			sync_cnt_q <= '0;
			line_y_q <= sco_pkg::LINE_Y_RST;
			retrace_seen_q <= 1'b0;
		end
		else
		begin
			blank_prev_q <= video_in.blank;
			sync_prev_q <= video_in.sync_n;
			line_y_q <= line_y_d;
			if (line_start)
			begin
				sync_cnt_q <= '0;
				retrace_seen_q <= (sync_cnt_q > sco_pkg::SYNC_CNT_RETRACE);
			end
			else if (video_in.blank && sync_prev_q && !video_in.sync_n && sync_cnt_q != sco_pkg::SYNC_CNT_MAX)
				sync_cnt_q <= sync_cnt_q + 1'b1;
		end
	end

	// X is the count of active pixels since blank ended
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in || video_in.blank)
			pix_x_q <= '0;
		else
			pix_x_q <= pix_x_q + 1'b1;
	end

	// Sprite window: origin is the pattern cell that lands on the cursor position
	assign rel_x = pix_x_q - pos_x_q + sco_pkg::COORD_W'(origin_x_q);
	assign rel_y = line_y_d - pos_y_q + sco_pkg::COORD_W'(origin_y_q);
	assign in_sprite = !video_in.blank && rel_x < 12'h040 && rel_y < 12'h040;

	// Byte holds four pixels, leftmost in the top two bits; row zero is the top
	assign spr_byte = pat_ram[{rel_y[sco_pkg::SPR_AW-1:0], rel_x[sco_pkg::SPR_AW-1:2]}];
	assign spr_bits = spr_byte[{~rel_x[1:0], 1'b1} -: 2];
	assign spr_kind = decode_bits(spr_bits, cursor_control_q[sco_pkg::CC_ALT_ENC]);
	assign sprite_vis = in_sprite && cursor_control_q[sco_pkg::CC_SPRITE_EN]
		&& spr_kind != sco_pkg::SCO_CUR_CLEAR;

	// Crosshair: thickness 1,3,5,7 gives half width 0..3 around the position
	assign half_w = sco_pkg::COORD_W'(cursor_control_q[sco_pkg::CC_WIDTH_LSB +: 2]);
	assign dx = abs_diff(pix_x_q, pos_x_q);
	assign dy = abs_diff(line_y_d, pos_y_q);
	assign xhair_on = !video_in.blank && cursor_control_q[sco_pkg::CC_XHAIR_EN]
		&& (dx <= half_w || dy <= half_w);
	assign xhair_rgb = cursor_control_q[sco_pkg::CC_XHAIR_COLOR] ? color1 : color0;

	always_comb
	begin
		case (spr_kind)
			sco_pkg::SCO_CUR_C0: spr_rgb = color0;
			sco_pkg::SCO_CUR_C1: spr_rgb = color1;
			sco_pkg::SCO_CUR_INVERT: spr_rgb = ~video_in.rgb;
			default: spr_rgb = video_in.rgb;
		endcase
	end

	// Overlap: bit5 clear lets the crosshair win, set lets the sprite win
	always_comb
	begin
		if (sprite_vis && xhair_on)
			rgb_d = cursor_control_q[sco_pkg::CC_ISECT] ? spr_rgb : xhair_rgb;
		else if (sprite_vis)
			rgb_d = spr_rgb;
		else if (xhair_on)
			rgb_d = xhair_rgb;
		else
			rgb_d = video_in.rgb;
	end

	// Output is one pixel clock behind the input, timing bits delayed alike
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			video_q.blank <= 1'b1;
			video_q.sync_n <= 1'b1;
			video_q.rgb <= '0;
		end
		else
		begin
			video_q.blank <= video_in.blank;
			video_q.sync_n <= video_in.sync_n;
			video_q.rgb <= rgb_d;
		end
	end

	assign video_out = video_q;

endmodule

// File: verif/sco_host.sv
`timescale 1ns/1ns
module sco_host
(
	input wire logic ref_clk_in,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	input wire logic [7:0] reg_rdata_in
);
	initial
	begin
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
	end
	// Released lines are inverted so a stale value is never read as good
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_out <= 1'b0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_out <= 1'b0;
		reg_addr_out <= ~a;
		@(negedge ref_clk_in);
		d = reg_rdata_in;
	endtask
	task automatic set_addr(input logic [9:0] a);
		wr(8'h08, a[7:0]);
		wr(8'h09, {6'h00, a[9:8]});
	endtask
endmodule

// File: verif/sco_overlay_properties.sv
`timescale 1ns/1ns
module sco_overlay_chk
(
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input sco_pkg::sco_video_type video_in,
	input sco_pkg::sco_video_type video_out
);
	logic [7:0] ctl_q;
	logic [5:0] ox_q;
	logic [9:0] pa_q;
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			ctl_q <= 8'h00;
			ox_q <= 6'h1F;
		end
		else if (reg_wr_in && reg_addr_in == 8'h06)
			ctl_q <= reg_wdata_in;
		else if (reg_wr_in && reg_addr_in == 8'h10)
			ox_q <= reg_wdata_in[5:0];
	end
	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
			pa_q <= 10'h000;
		else if (reg_wr_in && reg_addr_in == 8'h08)
			pa_q[7:0] <= reg_wdata_in;
		else if (reg_wr_in && reg_addr_in == 8'h09)
			pa_q[9:8] <= reg_wdata_in[1:0];
		else if ((reg_wr_in || reg_rd_in) && reg_addr_in == 8'h0A)
			pa_q <= pa_q + 10'h001;
	end
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (srst_in);
	sequence s_rd(logic [7:0] a);
		reg_rd_in && reg_addr_in == a;
	endsequence
	a_rdata_quiet: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data not idle");
	a_ctl_readback: assert property (s_rd(8'h06) |=> reg_rdata_out == $past(ctl_q))
		else $error("control readback wrong");
	a_addr_low: assert property (s_rd(8'h08) |=> reg_rdata_out == $past(pa_q[7:0]))
		else $error("address low wrong");
	a_addr_high: assert property (s_rd(8'h09) |=> reg_rdata_out == {6'h00, $past(pa_q[9:8])})
		else $error("address high wrong");
	a_origin_read: assert property (s_rd(8'h10) |=> reg_rdata_out == {2'b00, $past(ox_q)})
		else $error("origin readback wrong");
	a_sync_follows: assert property (!$past(srst_in) |-> video_out.sync_n == $past(video_in.sync_n))
		else $error("sync not delayed by one");
	a_blank_follows: assert property (!$past(srst_in) |-> video_out.blank == $past(video_in.blank))
		else $error("blank not delayed by one");
	a_plain_pass: assert property (!$past(srst_in) && (ctl_q & 8'h44) == 8'h00
		&& $past(ctl_q[6] | ctl_q[2]) == 1'b0 && !video_out.blank |-> video_out.rgb == $past(video_in.rgb))
		else $error("pixel altered with cursors off");
endmodule
bind sco_overlay sco_overlay_chk i_sco_overlay_chk (.ref_clk_in, .srst_in, .reg_addr_in, .reg_wdata_in,
	.reg_wr_in, .reg_rd_in, .reg_rdata_out, .video_in, .video_out);

// File: verif/sco_overlay_tb.sv
`timescale 1ns/1ns
module sco_overlay_tb;
	localparam logic [23:0] col0 = 24'h112233;
	localparam logic [23:0] col1 = 24'hAABBCC;
	logic ref_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] addr, wdata, rdata, got;
	logic wr, rd;
	sco_pkg::sco_video_type vin, vout;
	int failures = 0;
	int n_checks = 0;
	// Row: control value, then two-bit expectation per pixel (0 col0, 1 col1, 2 under, 3 inverse)
	logic [15:0] rows [9] = '{16'h401B, 16'h50A1, 16'h00AA, 16'h048A, 16'h0D56, 16'h0600, 16'h0700,
		16'h440B, 16'h641B};
	logic [15:0] setup [10] = '{16'h0C01, 16'h0E05, 16'h1001, 16'h1105, 16'h1211, 16'h1322, 16'h1433,
		16'h15AA, 16'h16BB, 16'h17CC};
	`define CHK(w, e, a) begin n_checks++; if ((a) !== (e)) begin failures++; $display("FAIL %s exp %h got %h", w, e, a); end end
	always #5 ref_clk_in = ~ref_clk_in;
	sco_host i_sco_host (.ref_clk_in, .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr),
		.reg_rd_out(rd), .reg_rdata_in(rdata));
	sco_overlay i_sco_overlay (.ref_clk_in, .srst_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .video_in(vin), .video_out(vout));
	function automatic logic [23:0] pick(input logic [1:0] k, input logic [23:0] u);
		pick = k == 2'h0 ? col0 : k == 2'h1 ? col1 : k == 2'h2 ? u : ~u;
	endfunction
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		i_sco_host.rd(a, got);
		`CHK("register", e, got)
	endtask
	// Two sync pulses in blank mark a retrace, one marks a plain line; porches kept above minimum
	task automatic frame(input logic [7:0] codes, input int nsync);
		logic [23:0] u;
		for (int i = 0; i < 90; i++)
		begin
			@(posedge ref_clk_in);
			vin <= '{1'b1, !(i == 2 || (nsync > 1 && i == 4)), 24'h000000};
		end
		for (int x = 0; x < 5; x++)
		begin
			u = 24'h5A3C90 + 24'(x);
			@(posedge ref_clk_in);
			vin <= '{x == 4, 1'b1, u};
			if (x > 0)
			begin
				@(negedge ref_clk_in);
				`CHK("pixel", pick(codes[9 - 2 * x -: 2], u - 24'h000001), vout.rgb)
			end
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Whole run is about 1200 cycles; this leaves ample margin
	initial
	begin
		#200000;
		failures++;
		tally_and_finish();
	end
	initial
	begin
		vin = '{1'b1, 1'b1, 24'h000000};
		repeat (20) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		rchk(8'h06, 8'h00);
		rchk(8'h10, 8'h1F);
		rchk(8'h11, 8'h1F);
		foreach (setup[i])
			i_sco_host.wr(setup[i][15:8], setup[i][7:0]);
		i_sco_host.set_addr(10'h000);
		i_sco_host.wr(8'h0A, 8'h1B);
		i_sco_host.wr(8'h0A, 8'h5A);
		i_sco_host.set_addr(10'h000);
		rchk(8'h0A, 8'h1B);
		rchk(8'h0A, 8'h5A);
		rchk(8'h08, 8'h02);
		i_sco_host.set_addr(10'h3FF);
		i_sco_host.wr(8'h0A, 8'h00);
		rchk(8'h08, 8'h00);
		i_sco_host.wr(8'h09, 8'hFF);
		rchk(8'h09, 8'h03);
		rchk(8'h40, 8'h00);
		$display("test registers done");
		foreach (rows[i])
		begin
			i_sco_host.wr(8'h06, rows[i][15:8]);
			frame(rows[i][7:0], 2);
		end
		rchk(8'h18, 8'h05);
		$display("test overlay done");
		i_sco_host.wr(8'h06, 8'h00);
		i_sco_host.set_addr(10'h010);
		i_sco_host.wr(8'h0A, 8'hFF);
		i_sco_host.wr(8'h06, 8'h40);
		frame(8'hFF, 1);
		rchk(8'h18, 8'h01);
		// Horizontal bar only: pixel 3 is reached through the row distance alone
		i_sco_host.wr(8'h0E, 8'h02);
		i_sco_host.wr(8'h06, 8'h05);
		frame(8'h00, 1);
		$display("test single sync done");
		@(posedge ref_clk_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		rchk(8'h06, 8'h00);
		i_sco_host.set_addr(10'h000);
		rchk(8'h0A, 8'h1B);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule
